// file: verilog/fts_defs.svh
// constants of the frame timestamp unit
// Operation
// R1: tag every transmitted pair with timestamp and sequence
// R2: capture microsecond time at frame arrival
// R3: no latency correction, arrival instant only
// R4: network pairs keep incoming timestamp and sequence
// R5: time server mode counts microseconds since epoch
// R6: free run from zero at reset
// R7: external mode clears counter on sync
// R8: signed timestamps, negative after later sync
// R9: only rising sync edge clears counter
// R10: pps input and trigger output exclusive
// R11: sequence increments per local pair, wraps
// R12: counter is 64-bit two's complement
`ifndef FTS_DEFS_SVH
`define FTS_DEFS_SVH
`define FTS_CLK_HZ     50000000
`define FTS_US_HZ      1000000
`define FTS_US_CYCLES  (`FTS_CLK_HZ / `FTS_US_HZ)
`define FTS_TS_W       64
`define FTS_SEQ_W      32
`define FTS_PRE_W      6
`define FTS_TS_RESET   64'h0000000000000000
`define FTS_SEQ_RESET  32'h00000000
`endif

// file: verilog/fts_pkg.sv
// types of the frame timestamp unit
`include "fts_defs.svh"
package fts_pkg;
    typedef enum logic [1:0] {SYNC_FREE, SYNC_SERVER, SYNC_PPS} sync_mode_e;
    typedef struct packed {
        logic signed [`FTS_TS_W-1:0] stamp;
        logic [`FTS_SEQ_W-1:0]       seq;
    } frame_tag_s;
endpackage : fts_pkg

// file: verilog/frame_timestamp_unit.sv
// microsecond clock and per-pair tagging
`timescale 1ns/1ps
`include "fts_defs.svh"
module frame_timestamp_unit (
    input  wire logic               CLK_SYS_IN,
    input  wire logic               RST_IN,
    input  wire logic [1:0]         SYNC_MODE_IN,
    input  wire logic               SERVER_LOAD_IN,
    input  wire logic signed [63:0] SERVER_TIME_IN,
    input  wire logic               SHARED_PIN_IN,
    input  wire logic               TRIG1_IN,
    output logic                    SHARED_PIN_OUT,
    output logic                    SHARED_PIN_OE_OUT,
    input  wire logic               FRAME_ARRIVE_IN,
    input  wire logic               PAIR_SEND_IN,
    input  wire logic               PAIR_FROM_NET_IN,
    input  wire fts_pkg::frame_tag_s NET_TAG_IN,
    output fts_pkg::frame_tag_s     TAG_OUT,
    output logic                    TAG_VALID_OUT,
    output logic signed [63:0]      TIME_OUT
);
    logic                    pin_s1_q, pin_s2_q, pin_s3_q;
    logic [`FTS_PRE_W-1:0]   pre_q;
    logic signed [63:0]      time_q, cap_q;
    logic [`FTS_SEQ_W-1:0]   seq_q;
    logic                    oe_q, trig_q;
    fts_pkg::frame_tag_s     tag_q;
    logic                    valid_q;

    // pps mode owns the pin, so trigger 1 drive is blocked
    wire pps_mode  = (SYNC_MODE_IN == 2'h2); // R10
    wire sync_rise = pps_mode & pin_s2_q & ~pin_s3_q; // R7 R9
    wire us_tick   = (pre_q == `FTS_PRE_W'(`FTS_US_CYCLES - 1));
    wire srv_load  = (SYNC_MODE_IN == 2'h1) & SERVER_LOAD_IN; // R5

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= SHARED_PIN_IN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // prescaler realigns on sync so the first microsecond is whole
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pre_q  <= '0;
            time_q <= `FTS_TS_RESET; // R6
        end else if (sync_rise) begin
            pre_q  <= '0;
            time_q <= `FTS_TS_RESET; // R7
        end else if (srv_load) begin
            pre_q  <= '0;
            time_q <= SERVER_TIME_IN; // R5
        end else begin
            pre_q  <= us_tick ? '0 : pre_q + 1'b1;
            time_q <= us_tick ? time_q + 64'sh1 : time_q; // R6 R12
        end
    end

    // capture at arrival; processing delay not subtracted
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cap_q <= `FTS_TS_RESET;
        end else if (FRAME_ARRIVE_IN) begin
            cap_q <= sync_rise ? `FTS_TS_RESET : time_q; // R2 R3
        end else if (sync_rise) begin
            // keep capture relative to new epoch: goes negative
            cap_q <= cap_q - time_q; // R8
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            seq_q   <= `FTS_SEQ_RESET;
            tag_q   <= '0;
            valid_q <= 1'b0;
        end else begin
            valid_q <= PAIR_SEND_IN; // R1
            if (PAIR_SEND_IN && PAIR_FROM_NET_IN) begin
                tag_q <= NET_TAG_IN; // R4
            end else if (PAIR_SEND_IN) begin
                tag_q.stamp <= cap_q; // R1
                tag_q.seq   <= seq_q;
                seq_q       <= seq_q + 1'b1; // R11
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            oe_q   <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            oe_q   <= ~pps_mode; // R10
            trig_q <= TRIG1_IN & ~pps_mode;
        end
    end

    assign SHARED_PIN_OUT    = trig_q;
    assign SHARED_PIN_OE_OUT = oe_q;
    assign TAG_OUT           = tag_q;
    assign TAG_VALID_OUT     = valid_q;
    assign TIME_OUT          = time_q;

    a_sync_clears: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        sync_rise |=> time_q == 64'sh0) else $error("sync did not clear time"); // R7
    a_rise_only: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (pin_s2_q && pin_s3_q && !srv_load) |=> time_q >= $past(time_q))
        else $error("level cleared time"); // R9
    a_tick_rate: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (time_q != $past(time_q) && !$past(sync_rise) && !$past(srv_load))
        |-> time_q == $past(time_q) + 64'sh1) else $error("bad step"); // R6 R12
    a_server_load: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (srv_load && !sync_rise) |=> time_q == $past(SERVER_TIME_IN))
        else $error("server time not loaded"); // R5
    a_capture: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (FRAME_ARRIVE_IN && !sync_rise) |=> cap_q == $past(time_q))
        else $error("capture wrong"); // R2 R3
    a_negative: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (sync_rise && !FRAME_ARRIVE_IN) |=> cap_q == $past(cap_q) - $past(time_q))
        else $error("rebase wrong"); // R8
    a_net_copy: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (PAIR_SEND_IN && PAIR_FROM_NET_IN) |=> TAG_OUT == $past(NET_TAG_IN) && TAG_VALID_OUT)
        else $error("net tag altered"); // R4 R1
    a_seq_step: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (PAIR_SEND_IN && !PAIR_FROM_NET_IN) |=> seq_q == $past(seq_q) + 1'b1
        && TAG_OUT.seq == $past(seq_q)) else $error("sequence wrong"); // R11
    a_pin_exclusive: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        pps_mode |=> !SHARED_PIN_OE_OUT) else $error("pin driven in pps"); // R10

    // steps of a pulse clear and of the two kinds of send
    sequence s_sync_seen;
        sync_rise;
    endsequence

    sequence s_counter_zero;
        time_q == 64'sh0;
    endsequence

    sequence s_local_send;
        PAIR_SEND_IN && !PAIR_FROM_NET_IN;
    endsequence

    sequence s_net_send;
        PAIR_SEND_IN && PAIR_FROM_NET_IN;
    endsequence

    // prescaler restarts on clear, so zero must last past the next edge
    a_zero_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R7
        s_sync_seen |=> s_counter_zero ##1 s_counter_zero)
        else $error("cleared time did not hold");

    a_valid_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R1
        PAIR_SEND_IN |=> TAG_VALID_OUT)
        else $error("send without valid");

    a_valid_idle: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R1
        !PAIR_SEND_IN |=> !TAG_VALID_OUT)
        else $error("valid without send");

    a_tag_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R1
        !PAIR_SEND_IN |=> $stable(TAG_OUT))
        else $error("tag moved between sends");

    a_local_stamp: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R1 R2
        s_local_send |=> TAG_OUT.stamp == $past(cap_q))
        else $error("local stamp not the capture");

    a_net_seq_keep: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R4 R11
        s_net_send |=> seq_q == $past(seq_q))
        else $error("net pair moved sequence");

    // all ones must roll to zero, never saturate
    a_seq_wrap: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R11
        (s_local_send and (seq_q == 32'hffffffff)) |=> seq_q == 32'h00000000)
        else $error("sequence did not wrap");

    a_trig_follow: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R10
        !pps_mode |=> SHARED_PIN_OUT == $past(TRIG1_IN) && SHARED_PIN_OE_OUT)
        else $error("trigger not driven");

    a_pps_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R10
        pps_mode |=> !SHARED_PIN_OUT)
        else $error("trigger level in pps");

    a_prescale_range: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R2
        pre_q <= `FTS_PRE_W'(`FTS_US_CYCLES - 1))
        else $error("prescaler out of range");

    // between ticks the time must stand, or the resolution is not one microsecond
    a_hold_between: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R2 R6
        (!us_tick && !sync_rise && !srv_load) |=> time_q == $past(time_q))
        else $error("time moved between ticks");

    a_load_refused: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R5
        (SERVER_LOAD_IN && SYNC_MODE_IN != 2'h1 && !sync_rise && !us_tick)
        |=> time_q == $past(time_q))
        else $error("load taken outside server mode");

    a_capture_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R7 R8
        (FRAME_ARRIVE_IN && sync_rise) |=> cap_q == 64'sh0)
        else $error("arrival at clear not zero");

    a_cap_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R3
        (!FRAME_ARRIVE_IN && !sync_rise) |=> $stable(cap_q))
        else $error("capture changed without arrival");
endmodule : frame_timestamp_unit

// file: verification/fts_partner.sv
// frame source and pulse-per-second source beside the timestamp unit
`timescale 1ns/1ps
module fts_partner (
    input  wire logic clk_in,
    input  wire logic arrive_req_in,
    input  wire logic pps_req_in,
    output logic      frame_out,
    output logic      pps_out
);
    // requests taken on the rising edge so the bench's falling-edge writes never race
    logic arrive_q = 1'b0;
    logic pps_q    = 1'b0;
    initial frame_out = 1'b0;
    initial pps_out = 1'b0;
    always @(posedge clk_in) begin
        arrive_q <= arrive_req_in;
        pps_q    <= pps_req_in;
    end
    // both sources change off the sampling edge, like real pins
    always @(negedge clk_in) begin
        frame_out <= arrive_q;
        pps_out   <= pps_q;
    end
endmodule : fts_partner

// file: verification/test_frame_timestamp_unit.sv
// self-checking bench of the frame timestamp unit
`timescale 1ns/1ps
module test_frame_timestamp_unit;
    logic clk = 0, rst = 1, load = 0, trig1 = 0, send = 0, net = 0, areq = 0, preq = 0;
    logic [1:0]          mode = 2'h0;
    logic signed [63:0]  srv = 64'h0, now;
    fts_pkg::frame_tag_s ntag = '0, tag, t1;
    logic                valid, pout, poe, arrive, pps, pin;
    int                  errors = 0, cmp_count = 0, cycles = 0;
    always #10 clk = ~clk;
    // shared pin level: unit drives it unless in reset or pps mode
    assign pin = poe ? pout : pps;
    fts_partner src (.clk_in(clk), .arrive_req_in(areq), .pps_req_in(preq), .frame_out(arrive),
        .pps_out(pps));
    frame_timestamp_unit dut (.CLK_SYS_IN(clk), .RST_IN(rst), .SYNC_MODE_IN(mode),
        .SERVER_LOAD_IN(load), .SERVER_TIME_IN(srv), .SHARED_PIN_IN(pin), .TRIG1_IN(trig1),
        .SHARED_PIN_OUT(pout), .SHARED_PIN_OE_OUT(poe), .FRAME_ARRIVE_IN(arrive),
        .PAIR_SEND_IN(send), .PAIR_FROM_NET_IN(net), .NET_TAG_IN(ntag), .TAG_OUT(tag),
        .TAG_VALID_OUT(valid), .TIME_OUT(now));
    task end_sim;
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task chk(input logic [95:0] exp, input logic [95:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task capture;
        areq = 1;
        step(1);
        areq = 0;
        step(2);
    endtask : capture
    task pair(input logic from_net);
        net = from_net;
        send = 1;
        step(1);
        send = 0;
        chk(96'h1, valid);
        step(1);
        chk(96'h0, valid);
    endtask : pair
    task test_free;
        chk(96'h0, now);
        trig1 = 1;
        capture();
        pair(0);
        t1 = tag;
        chk(96'h0, t1.seq);
        chk(96'h0, t1.stamp);
        chk(96'h3, {pout, poe});
        step(495);
        capture();
        pair(0);
        chk(t1.stamp + 64'sh0a, tag.stamp);
        chk(t1.seq + 32'h1, tag.seq);
    endtask : test_free
    task test_net;
        ntag = {64'hfedcba9876543210, 32'h89abcdef};
        pair(1);
        chk(ntag, tag);
        pair(0);
        chk(96'h2, tag.seq);
    endtask : test_net
    task test_server;
        mode = 2'h1;
        srv = 64'h0005a1b2c3d4e5f6;
        load = 1;
        step(1);
        load = 0;
        step(1);
        chk(srv, now);
        mode = 2'h0;
        load = 1;
        srv = 64'h0000000000000777;
        step(1);
        load = 0;
        step(1);
        chk(64'h0005a1b2c3d4e5f6, now);
    endtask : test_server
    task test_pps;
        mode = 2'h2;
        step(2);
        chk(96'h0, poe);
        capture();
        step(100);
        preq = 1;
        step(6);
        chk(96'h0, now);
        pair(0);
        chk(96'h1, tag.stamp[63]);
        step(100);
        preq = 0;
        step(6);
        chk(96'h2, now);
    endtask : test_pps
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        step(12);
        rst = 0;
        test_free();
        test_net();
        test_server();
        test_pps();
        end_sim();
    end
endmodule : test_frame_timestamp_unit
